/* File: sfp_defines.vh */
`ifndef SFP_DEFINES_VH
`define SFP_DEFINES_VH

// Queue geometry
`define SFP_DATA_W      36
`define SFP_ADDR_W      4
`define SFP_OFS_W       4
// Reset values
`define SFP_PTR_RST     4'h0
`define SFP_WORD_RST    36'h0
`define SFP_OFS_EMPTY_RST 4'h2
`define SFP_OFS_FULL_RST  4'h2
// Strap encodings
`define SFP_STRAP_SYNC  1'b1
`define SFP_STRAP_ASYNC 1'b0

`endif

/* File: sfp_edge_sync.v */
`timescale 1ns/1ps
// Two-stage synchroniser with rising-edge pulse; only stage two feeds logic
module sfp_edge_sync (
  input  wire clk,
  input  wire rst,
  input  wire pinIn,
  output wire level,
  output wire rise
);
  reg meta_r;
  reg sync_r;
  reg last_r;

  always @(posedge clk) begin
    if (rst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      meta_r <= pinIn;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign level = sync_r;
  assign rise  = sync_r & ~last_r;
endmodule // sfp_edge_sync

/* File: sfp_port_ctrl.v */
`timescale 1ns/1ps
`include "sfp_defines.vh"

module sfp_port_ctrl #(
  parameter DATA_W = `SFP_DATA_W,
  parameter ADDR_W = `SFP_ADDR_W,
  parameter OFS_W  = `SFP_OFS_W
) (
  input  wire              clk,
  input  wire              rst,
  input  wire              fullReset,
  input  wire              inputPortAsyncSelect,
  input  wire              outputPortAsyncSelect,
  input  wire              fallThroughMode,
  input  wire              writeClk,
  input  wire              writeEnableN,
  input  wire              offsetLoadN,
  input  wire              serialOffsetLoadEnableN,
  input  wire              serialIn,
  input  wire [DATA_W-1:0] dataIn,
  input  wire              readClk,
  input  wire              readEnableN,
  output reg  [DATA_W-1:0] dataOut,
  output reg               emptyN,
  output reg               fullN,
  output reg               writeSync,
  output reg               readSync,
  output reg               modeError
);
  localparam DEPTH = 1 << ADDR_W;

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  ////////////////////////////////////////////////////////////////////
  reg [1:0] wenS_r;
  reg [1:0] renS_r;
  reg [1:0] ldS_r;
  reg [1:0] senS_r;
  reg [1:0] sinS_r;
  reg [1:0] frS_r;
  reg [1:0] input_port_async_select_r;
  reg [1:0] output_port_async_select_r;
  reg [1:0] ftS_r;
  reg [DATA_W-1:0] dMeta_r;
  reg [DATA_W-1:0] dSync_r;
  wire wRise;
  wire rRise;

  always @(posedge clk) begin
    if (rst) begin
      wenS_r  <= 2'h3;
      renS_r  <= 2'h3;
      ldS_r   <= 2'h3;
      senS_r  <= 2'h3;
      sinS_r  <= 2'h0;
      frS_r   <= 2'h0;
      input_port_async_select_r  <= 2'h3;
      output_port_async_select_r  <= 2'h3;
      ftS_r   <= 2'h0;
      dMeta_r <= `SFP_WORD_RST;
      dSync_r <= `SFP_WORD_RST;
    end else begin
      wenS_r  <= {wenS_r[0], writeEnableN};
      renS_r  <= {renS_r[0], readEnableN};
      ldS_r   <= {ldS_r[0], offsetLoadN};
      senS_r  <= {senS_r[0], serialOffsetLoadEnableN};
      sinS_r  <= {sinS_r[0], serialIn};
      frS_r   <= {frS_r[0], fullReset};
      input_port_async_select_r  <= {input_port_async_select_r[0], inputPortAsyncSelect};
      output_port_async_select_r  <= {output_port_async_select_r[0], outputPortAsyncSelect};
      ftS_r   <= {ftS_r[0], fallThroughMode};
      dMeta_r <= dataIn;
      dSync_r <= dMeta_r;
    end
  end

  sfp_edge_sync uWclk (
    .clk   (clk),
    .rst   (rst),
    .pinIn (writeClk),
    .level (),
    .rise  (wRise)
  );

  sfp_edge_sync uRclk (
    .clk   (clk),
    .rst   (rst),
    .pinIn (readClk),
    .level (),
    .rise  (rRise)
  );

  ////////////////////////////////////////////////////////////////////
  // Queue and offsets
  ////////////////////////////////////////////////////////////////////
  reg [DATA_W-1:0] mem_r [0:DEPTH-1];
  reg [ADDR_W:0]   wPtr_r;
  reg [ADDR_W:0]   rPtr_r;
  reg [OFS_W-1:0]  ofsEmpty_r;
  reg [OFS_W-1:0]  ofsFull_r;
  reg              ofsSel_r;
  reg              rdOfsSel_r;
  reg [OFS_W-1:0]  serCnt_r;
  integer i;

  function [ADDR_W:0] ptrInc;
    input [ADDR_W:0] p;
    begin
      ptrInc = p + {{ADDR_W{1'b0}}, 1'b1};
    end
  endfunction

  wire isFull  = (wPtr_r[ADDR_W] != rPtr_r[ADDR_W]) &&
                 (wPtr_r[ADDR_W-1:0] == rPtr_r[ADDR_W-1:0]);
  wire isEmpty = (wPtr_r == rPtr_r);
  // Async mode leans on the writer tying enable active, so the strobe alone counts
  wire wQual   = writeSync ? ~wenS_r[1] : 1'b1;
  wire wEvt    = wRise & wQual;
  wire rQual   = readSync ? ~renS_r[1] : 1'b1;
  wire rEvt    = rRise & rQual;
  wire ldOn    = ~ldS_r[1];
  wire doWrite = wEvt & ~ldOn & ~isFull;
  wire doRead  = rEvt & ~ldOn & ~isEmpty;
  wire serOn   = ~senS_r[1] & ldOn;

  always @(posedge clk) begin
    if (rst || frS_r[1]) begin
      wPtr_r     <= {1'b0, `SFP_PTR_RST};
      rPtr_r     <= {1'b0, `SFP_PTR_RST};
      dataOut    <= `SFP_WORD_RST;
      writeSync  <= input_port_async_select_r[1];
      readSync   <= output_port_async_select_r[1];
      modeError  <= (output_port_async_select_r[1] == `SFP_STRAP_ASYNC) & ftS_r[1];
      ofsEmpty_r <= `SFP_OFS_EMPTY_RST;
      ofsFull_r  <= `SFP_OFS_FULL_RST;
      ofsSel_r   <= 1'b0;
      rdOfsSel_r <= 1'b0;
      serCnt_r   <= {OFS_W{1'b0}};
      emptyN     <= 1'b0;
      fullN      <= 1'b1;
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_r[i] <= `SFP_WORD_RST;
      end
    end else begin
      // Straps are held after reset by the system, so no re-capture here
      if (doWrite) begin
        mem_r[wPtr_r[ADDR_W-1:0]] <= dSync_r;
        wPtr_r <= ptrInc(wPtr_r);
      end
      if (wEvt & ldOn & ~serOn) begin
        if (ofsSel_r)
          ofsFull_r <= dSync_r[OFS_W-1:0];
        else
          ofsEmpty_r <= dSync_r[OFS_W-1:0];
        ofsSel_r <= ~ofsSel_r;
      end
      // Serial bits shift in on write-clock rises, empty offset first
      if (wRise & serOn) begin
        if (ofsSel_r)
          ofsFull_r <= {sinS_r[1], ofsFull_r[OFS_W-1:1]};
        else
          ofsEmpty_r <= {sinS_r[1], ofsEmpty_r[OFS_W-1:1]};
        if (serCnt_r == OFS_W - 1) begin
          serCnt_r <= {OFS_W{1'b0}};
          ofsSel_r <= ~ofsSel_r;
        end else begin
          serCnt_r <= serCnt_r + {{(OFS_W-1){1'b0}}, 1'b1};
        end
      end
      if (doRead) begin
        dataOut <= mem_r[rPtr_r[ADDR_W-1:0]];
        rPtr_r  <= ptrInc(rPtr_r);
      end else if (rEvt & ldOn & readSync) begin
        dataOut    <= {{(DATA_W-OFS_W){1'b0}}, rdOfsSel_r ? ofsFull_r : ofsEmpty_r};
        rdOfsSel_r <= ~rdOfsSel_r;
      end
      emptyN <= ~((wPtr_r == (doRead ? ptrInc(rPtr_r) : rPtr_r)) && !doWrite) |
                (doWrite & ~doRead);
      fullN  <= ~(isFull & ~doRead) & ~(doWrite & ~doRead &
                (ptrInc(wPtr_r) == {~rPtr_r[ADDR_W], rPtr_r[ADDR_W-1:0]}));
    end
  end
endmodule // sfp_port_ctrl

/* File: sfp_port_ctrl_sva.sv */
`timescale 1ns/1ps
module sfp_port_ctrl_sva (
  input wire        clk,
  input wire        rst,
  input wire        fullReset,
  input wire        inputPortAsyncSelect,
  input wire        outputPortAsyncSelect,
  input wire        fallThroughMode,
  input wire        writeClk,
  input wire        writeEnableN,
  input wire        offsetLoadN,
  input wire        readEnableN,
  input wire [35:0] dataOut,
  input wire        emptyN,
  input wire        fullN,
  input wire        writeSync,
  input wire        readSync,
  input wire        modeError
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  property p_wcap; fullReset[*5] |=> writeSync == $past(inputPortAsyncSelect, 3); endproperty
  a_wcap: assert property (p_wcap) else $error("write strap");
  property p_rcap; fullReset[*5] |=> readSync == $past(outputPortAsyncSelect, 3); endproperty
  a_rcap: assert property (p_rcap) else $error("read strap");
  property p_merr; fullReset[*5] |=> modeError == (!readSync && $past(fallThroughMode, 3)); endproperty
  a_merr: assert property (p_merr) else $error("mode flag");
  property p_clr; fullReset[*5] |=> !emptyN && fullN && dataOut == 36'h0; endproperty
  a_clr: assert property (p_clr) else $error("reset state");
  // Flag latency bounds the strobe edge detector plus one write cycle
  property p_take; $rose(writeClk) && offsetLoadN && (!writeSync || !writeEnableN) && !emptyN && !fullReset
    |-> ##[3:6] emptyN; endproperty
  a_take: assert property (p_take) else $error("write lost");
  // Enable and load pins pass two flops, so the write that lifts the flag saw them three cycles back
  property p_qual; $rose(emptyN) |-> $past(offsetLoadN, 3) && (!writeSync || !$past(writeEnableN, 3)); endproperty
  a_qual: assert property (p_qual) else $error("bad write");
  property p_full; !fullN && readSync && readEnableN |=> !fullN; endproperty
  a_full: assert property (p_full) else $error("full lost");
  property p_rdq; $fell(emptyN) && !fullReset |-> !readSync || !$past(readEnableN, 3); endproperty
  a_rdq: assert property (p_rdq) else $error("bad read");
  c_full: cover property (!fullN);
  c_async: cover property ($rose(emptyN) && !writeSync);
  c_merr: cover property (modeError);
endmodule // sfp_port_ctrl_sva
bind sfp_port_ctrl sfp_port_ctrl_sva u_sva (.*);

/* File: sfp_strobe_model.sv */
`timescale 1ns/1ps
module sfp_strobe_model (
  output logic strobe
);
  initial strobe = 1'b0;
  // Idle low between frames; edges sit off the 4 ns grid so sampling never races
  // Frame is 47 ns, so a caller that re-aligns to the next clock edge gets a 48 ns period
  task pulse;
    #5 strobe = 1'b1;
    #24 strobe = 1'b0;
    #18;
  endtask
endmodule // sfp_strobe_model

/* File: tb_sfp_port_ctrl.sv */
`timescale 1ns/1ps
module tb_sfp_port_ctrl;
  logic        clk = 0, rst = 1, fullReset = 0, wSel = 1, rSel = 1, ftMode = 0;
  logic        writeEnableN = 1, offsetLoadN = 1, serialEnN = 1, readEnableN = 1;
  logic [35:0] dataIn = 36'h0, d;
  logic [35:0] q[$];
  logic [2:0]  cfg [4] = '{3'b110, 3'b000, 3'b101, 3'b100};
  wire  [35:0] dataOut;
  wire         writeClk, readClk, emptyN, fullN, writeSync, readSync, modeError;
  integer      num_errors = 0, n_compared = 0, seed = 6, cyc = 0, i, k = 0;
  always #2 clk = ~clk;
  sfp_strobe_model wm (.strobe(writeClk));
  sfp_strobe_model rm (.strobe(readClk));
  sfp_port_ctrl dut (.clk(clk), .rst(rst), .fullReset(fullReset), .inputPortAsyncSelect(wSel),
    .outputPortAsyncSelect(rSel), .fallThroughMode(ftMode), .writeClk(writeClk), .writeEnableN(writeEnableN),
    .offsetLoadN(offsetLoadN), .serialOffsetLoadEnableN(serialEnN), .serialIn(dataIn[0]), .dataIn(dataIn),
    .readClk(readClk), .readEnableN(readEnableN), .dataOut(dataOut), .emptyN(emptyN), .fullN(fullN),
    .writeSync(writeSync), .readSync(readSync), .modeError(modeError));
  ////////////////////////////////////////////////////////////////
  task chk(input logic [37:0] seen, input logic [37:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task wr(input bit push);
    d = {4'(k), 32'($random(seed))};
    @(posedge clk) dataIn <= d;
    if (push) q.push_back(d);
    wm.pulse;
  endtask
  // Read data settle a few clocks after the strobe edge is seen
  always @(posedge readClk) begin
    repeat (6) @(posedge clk);
    chk(dataOut, q.pop_front());
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      num_errors = num_errors + 1;
      print_verdict;
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    for (i = 0; i < 4; i++) begin
      @(posedge clk) {wSel, rSel, ftMode} <= cfg[i];
      repeat (4) @(posedge clk);
      fullReset <= 1;
      repeat (8) @(posedge clk);
      fullReset <= 0;
      repeat (6) @(posedge clk);
      chk(writeSync, wSel);
      chk(readSync, rSel);
      chk(modeError, !rSel && ftMode);
      chk({emptyN, fullN, dataOut}, {2'b01, 36'h0});
      if (i == 2) begin
        $display("config %0d done", i);
        continue;
      end
      writeEnableN <= (i == 0);
      readEnableN <= rSel;
      if (i == 0) begin
        wr(0);
        @(posedge clk) {writeEnableN, offsetLoadN, serialEnN} <= 3'b000;
        wr(0);
        @(posedge clk) {serialEnN, readEnableN} <= 2'b10;
        q.push_back({32'h0, d[0], 3'b001});
        rm.pulse;
        wr(0);
        wr(0);
        q.push_back({32'h0, d[3:0]});
        @(posedge clk);
        rm.pulse;
        @(posedge clk) {offsetLoadN, readEnableN} <= 2'b11;
        repeat (8) @(posedge clk);
        chk(emptyN, 0);
      end
      for (k = 0; k < 17; k++) wr(k < 16);
      repeat (8) @(posedge clk);
      chk(fullN, 0);
      @(posedge clk) readEnableN <= 0;
      for (k = 0; k < 16; k++) begin
        @(posedge clk);
        rm.pulse;
      end
      repeat (8) @(posedge clk);
      chk(emptyN, 0);
      $display("config %0d done", i);
    end
    print_verdict;
  end
endmodule // tb_sfp_port_ctrl
